// *** logic/qsq_pkg.sv ***
`default_nettype none
package qsq_pkg;
    localparam int ENTRIES = 16;
    localparam int PTR_W = 4;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int CNT_W = 5;
    localparam int GAP_W = 14;

    // Register map, word addresses on the plain port
    localparam logic [1:0] SEG_CMD = 2'h0;
    localparam logic [1:0] SEG_TX = 2'h1;
    localparam logic [1:0] SEG_RX = 2'h2;
    localparam logic [1:0] SEG_CTRL = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 6'h30;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 6'h31;
    localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 6'h32;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 6'h33;

    localparam logic [15:0] CTRL0_RST = 16'h0040;
    localparam logic [15:0] CTRL1_RST = 16'h0000;
    localparam logic [15:0] CTRL2_RST = 16'hf000;
    localparam int STAT_DONE_BIT = 7;
    localparam int STAT_FAULT_BIT = 6;

    localparam logic [CNT_W-1:0] BYTE_BITS = 5'h08;
    localparam logic [CNT_W-1:0] FULL_BITS = 5'h10;
    localparam logic [GAP_W-1:0] STD_POST_GAP = 14'h0011;
    localparam int POST_GAP_SHIFT = 5;

    typedef struct packed {
        logic keep_selects;
        logic width_select;
        logic post_gap_on;
        logic lead_gap_on;
        logic [3:0] periph_select;
    } qsq_cmd_s;

    typedef struct packed {
        logic master_mode_bit;
        logic [2:0] rsvd;
        logic [7:0] sck_half;
        logic [3:0] bit_count;
    } qsq_ctrl0_s;

    typedef struct packed {
        logic serial_enable;
        logic [6:0] lead_gap_len;
        logic [7:0] post_gap_len;
    } qsq_ctrl1_s;

    typedef struct packed {
        logic [3:0] port_pin_control;
        logic [3:0] queue_last_ptr;
        logic [3:0] rsvd;
        logic [3:0] queue_first_ptr;
    } qsq_ctrl2_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_LEAD = 3'b010,
        ST_XFER = 3'b011,
        ST_POST = 3'b100,
        ST_SLAVE = 3'b101
    } qsq_state_e;

    function automatic logic [CNT_W-1:0] qsq_nbits(input logic wide, input logic [3:0] cnt);
        if (!wide) begin
            return BYTE_BITS;
        end
        return (cnt == 4'h0) ? FULL_BITS : {1'b0, cnt};
    endfunction : qsq_nbits

    function automatic logic [DATA_W-1:0] qsq_mask(input logic [CNT_W-1:0] n);
        logic [DATA_W:0] one;
        one = '0;
        one[n] = 1'b1;
        return DATA_W'(one - 1'b1);
    endfunction : qsq_mask
endpackage : qsq_pkg
`default_nettype wire

// *** logic/qsq_queue.sv ***
// Local design decisions: strobed register access and the register offsets.
`default_nettype none
module qsq_queue
    import qsq_pkg::*;
#(
    parameter logic [GAP_W-1:0] POST_GAP_ZERO = 14'h2000
) (
    input wire logic CORE_CLK, // System clock
    input wire logic RSTN, // Synchronous reset, low
    input wire logic CE, // Clock enable
    input wire logic [ADDR_W-1:0] ADDR, // Register word address
    input wire logic [DATA_W-1:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [DATA_W-1:0] RDATA, // Read data, cycle after strobe
    output logic SCK_O, // Serial clock out
    output logic SCK_OE, // Serial clock drive enable
    input wire logic SCK_I, // Serial clock in
    output logic MOSI_O, // Master data out
    output logic MOSI_OE, // Master data drive enable
    input wire logic MOSI_I, // Master data in
    output logic MISO_O, // Slave data out
    output logic MISO_OE, // Slave data drive enable
    input wire logic MISO_I, // Slave data in
    output logic [3:0] CS_O, // Chip select levels
    output logic [3:0] CS_OE, // Chip select drive enables
    input wire logic SS_N_I, // Slave select, shares chip select 0
    output logic QUEUE_DONE, // Queue done flag
    output logic MODE_FAULT // Mode fault flag
);
    logic [7:0] cmd_mem [ENTRIES];
    logic [DATA_W-1:0] tx_mem [ENTRIES];
    logic [DATA_W-1:0] rx_mem [ENTRIES];
    qsq_ctrl0_s ctrl0_reg;
    qsq_ctrl1_s ctrl1_reg;
    qsq_ctrl2_s ctrl2_reg;
    qsq_state_e state_reg;
    qsq_cmd_s cmd_reg;
    qsq_cmd_s cmd_next;
    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] cpt_reg;
    logic [GAP_W-1:0] gap_reg;
    logic [7:0] div_reg;
    logic [CNT_W-1:0] bit_reg;
    logic [CNT_W-1:0] nbits_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic sck_reg;
    logic [3:0] cs_reg;
    logic done_reg;
    logic fault_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] hist_reg;
    logic ss_low;
    logic ss_fall;
    logic sck_rise;
    logic sck_fall;
    logic master;
    logic enabled;
    logic start;
    logic m_tick;
    logic m_sample;
    logic m_shift;
    logic s_shift;
    logic xfer_end;
    logic slv_end;
    logic fault_set;
    logic [7:0] half;
    logic [GAP_W-1:0] lead_cycles;
    logic [GAP_W-1:0] post_cycles;
    logic sh_load;
    logic sh_out;
    logic [DATA_W-1:0] sh_rx;
    logic [CNT_W-1:0] sh_nbits;

    assign master = ctrl0_reg.master_mode_bit;
    assign enabled = ctrl1_reg.serial_enable;
    assign half = (ctrl0_reg.sck_half == 8'h00) ? 8'h01 : ctrl0_reg.sck_half;
    assign cmd_next = qsq_cmd_s'(cmd_mem[ptr_reg]);

    // Pins from outside pass two flops before use
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            // Idle pin levels, so no false clock edge follows reset
            sync1_reg <= 4'hb;
            sync2_reg <= 4'hb;
            hist_reg <= 2'h2;
        end else if (CE) begin
            sync1_reg <= {SS_N_I, SCK_I, MOSI_I, MISO_I};
            sync2_reg <= sync1_reg;
            hist_reg <= sync2_reg[3:2];
        end
    end

    assign ss_low = !sync2_reg[3];
    assign ss_fall = hist_reg[1] && !sync2_reg[3];
    assign sck_rise = !hist_reg[0] && sync2_reg[2];
    assign sck_fall = hist_reg[0] && !sync2_reg[2];

    // Register writes; the serial side never writes command or transmit store
    always_ff @(posedge CORE_CLK) begin
        if (CE && WR && ADDR[5:4] == SEG_CMD) begin
            cmd_mem[ADDR[3:0]] <= WDATA[7:0];
        end
        if (CE && WR && ADDR[5:4] == SEG_TX) begin
            tx_mem[ADDR[3:0]] <= WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (CE && (xfer_end || slv_end)) begin
            rx_mem[ptr_reg] <= sh_rx;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ctrl0_reg <= qsq_ctrl0_s'(CTRL0_RST);
            ctrl1_reg <= qsq_ctrl1_s'(CTRL1_RST);
            ctrl2_reg <= qsq_ctrl2_s'(CTRL2_RST);
        end else if (CE && WR) begin
            case (ADDR)
                ADDR_CTRL0: ctrl0_reg <= qsq_ctrl0_s'({WDATA[15], 3'h0, WDATA[11:0]});
                ADDR_CTRL1: ctrl1_reg <= qsq_ctrl1_s'(WDATA);
                ADDR_CTRL2: ctrl2_reg <= qsq_ctrl2_s'({WDATA[15:8], 4'h0, WDATA[3:0]});
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rdata_reg <= '0;
        end else if (CE) begin
            rdata_reg <= '0;
            if (RD) begin
                case (ADDR[5:4])
                    SEG_CMD: rdata_reg <= {8'h00, cmd_mem[ADDR[3:0]]};
                    SEG_TX: rdata_reg <= tx_mem[ADDR[3:0]];
                    SEG_RX: rdata_reg <= rx_mem[ADDR[3:0]];
                    default: begin
                        case (ADDR)
                            ADDR_CTRL0: rdata_reg <= ctrl0_reg;
                            ADDR_CTRL1: rdata_reg <= ctrl1_reg;
                            ADDR_CTRL2: rdata_reg <= ctrl2_reg;
                            ADDR_STAT: rdata_reg <= {8'h00, done_reg, fault_reg, 2'h0, cpt_reg};
                            default: rdata_reg <= '0;
                        endcase
                    end
                endcase
            end
        end
    end
    assign RDATA = rdata_reg;

    // Master queue starts on a write that sets serial enable
    assign start = WR && ADDR == ADDR_CTRL1 && WDATA[15] && master;
    assign m_tick = state_reg == ST_XFER && div_reg == 8'h01;
    assign m_sample = m_tick && !sck_reg;
    assign m_shift = m_tick && sck_reg;
    assign xfer_end = m_shift && bit_reg + 1'b1 == nbits_reg;
    assign s_shift = state_reg == ST_SLAVE && sck_fall;
    assign slv_end = s_shift && bit_reg + 1'b1 == nbits_reg;

    assign lead_cycles = !cmd_next.lead_gap_on ? GAP_W'(half) :
        (ctrl1_reg.lead_gap_len == 7'h00) ? GAP_W'(1) : GAP_W'(ctrl1_reg.lead_gap_len);
    assign post_cycles = !cmd_reg.post_gap_on ? STD_POST_GAP :
        (ctrl1_reg.post_gap_len == 8'h00) ? POST_GAP_ZERO :
        GAP_W'({ctrl1_reg.post_gap_len, 5'h00});

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state_reg <= ST_IDLE;
        end else if (CE) begin
            // The enabling write itself must reach the start decode
            if (!enabled && !start) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (start) begin
                            state_reg <= ST_LOAD;
                        end else if (!master && ss_fall) begin
                            state_reg <= ST_SLAVE;
                        end
                    end
                    ST_LOAD: state_reg <= ST_LEAD;
                    ST_LEAD: state_reg <= (gap_reg == GAP_W'(1)) ? ST_XFER : ST_LEAD;
                    ST_XFER: state_reg <= xfer_end ? ST_POST : ST_XFER;
                    ST_POST: begin
                        if (gap_reg == GAP_W'(1)) begin
                            state_reg <= (ptr_reg == ctrl2_reg.queue_last_ptr) ? ST_IDLE : ST_LOAD;
                        end
                    end
                    ST_SLAVE: state_reg <= (slv_end || !ss_low) ? ST_IDLE : ST_SLAVE;
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Queue pointer walks first through last, wrapping at sixteen entries
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            ptr_reg <= '0;
            cpt_reg <= '0;
        end else if (CE) begin
            if (state_reg == ST_IDLE && start) begin
                ptr_reg <= ctrl2_reg.queue_first_ptr;
            end else if (!enabled) begin
                // Parked at the first entry so slave transfers begin there
                ptr_reg <= ctrl2_reg.queue_first_ptr;
            end else if (state_reg == ST_POST && gap_reg == GAP_W'(1)) begin
                cpt_reg <= ptr_reg;
                ptr_reg <= ptr_reg + 1'b1;
            end else if (slv_end) begin
                cpt_reg <= ptr_reg;
                ptr_reg <= (ptr_reg == ctrl2_reg.queue_last_ptr) ?
                    ctrl2_reg.queue_first_ptr : ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            cmd_reg <= '0;
            nbits_reg <= BYTE_BITS;
        end else if (CE) begin
            if (state_reg == ST_LOAD) begin
                cmd_reg <= cmd_next;
                nbits_reg <= qsq_nbits(cmd_next.width_select, ctrl0_reg.bit_count);
            end else if (state_reg == ST_IDLE && !master) begin
                nbits_reg <= qsq_nbits(1'b1, ctrl0_reg.bit_count);
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            gap_reg <= '0;
        end else if (CE) begin
            if (state_reg == ST_LOAD) begin
                gap_reg <= lead_cycles;
            end else if (xfer_end) begin
                gap_reg <= post_cycles;
            end else if (gap_reg != '0) begin
                gap_reg <= gap_reg - 1'b1;
            end
        end
    end

    // Serial clock divider, idle low, sample on rise, shift on fall
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            sck_reg <= 1'b0;
            div_reg <= 8'h01;
            bit_reg <= '0;
        end else if (CE) begin
            if (state_reg != ST_XFER && state_reg != ST_SLAVE) begin
                sck_reg <= 1'b0;
                div_reg <= half;
                bit_reg <= '0;
            end else begin
                if (state_reg == ST_XFER) begin
                    div_reg <= m_tick ? half : div_reg - 1'b1;
                    sck_reg <= m_tick ? !sck_reg : sck_reg;
                end
                if (m_shift || s_shift) begin
                    bit_reg <= bit_reg + 1'b1;
                end
            end
        end
    end

    // Select pins: command pattern while active, port levels when released
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            cs_reg <= CTRL2_RST[15:12];
        end else if (CE) begin
            if (!enabled || !master) begin
                cs_reg <= ctrl2_reg.port_pin_control;
            end else if (state_reg == ST_LOAD) begin
                cs_reg <= cmd_next.periph_select;
            end else if (xfer_end && !cmd_reg.keep_selects) begin
                cs_reg <= ctrl2_reg.port_pin_control;
            end
        end
    end

    // Own drive high yet pin seen low means another master pulls select
    assign fault_set = master && enabled && ss_low && cs_reg[0];

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else if (CE) begin
            // Set beats a simultaneous write-one clear
            if (state_reg == ST_POST && gap_reg == GAP_W'(1) &&
                ptr_reg == ctrl2_reg.queue_last_ptr) begin
                done_reg <= 1'b1;
            end else if (slv_end && ptr_reg == ctrl2_reg.queue_last_ptr) begin
                done_reg <= 1'b1;
            end else if (WR && ADDR == ADDR_STAT && WDATA[STAT_DONE_BIT]) begin
                done_reg <= 1'b0;
            end
            if (fault_set) begin
                fault_reg <= 1'b1;
            end else if (WR && ADDR == ADDR_STAT && WDATA[STAT_FAULT_BIT]) begin
                fault_reg <= 1'b0;
            end
        end
    end

    assign sh_load = state_reg == ST_LOAD || (state_reg == ST_IDLE && !master && ss_fall);
    assign sh_nbits = (state_reg == ST_LOAD) ?
        qsq_nbits(cmd_next.width_select, ctrl0_reg.bit_count) : nbits_reg;

    qsq_shifter #(
        .W(DATA_W)
    ) u_shifter (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .ce(CE),
        .load(sh_load),
        .load_data(tx_mem[ptr_reg]),
        .nbits(sh_load ? (state_reg == ST_LOAD ? sh_nbits : qsq_nbits(1'b1,
            ctrl0_reg.bit_count)) : nbits_reg),
        .sample(m_sample || (state_reg == ST_SLAVE && sck_rise)),
        .in_bit(master ? sync2_reg[0] : sync2_reg[1]),
        .shift(m_shift || s_shift),
        .out_bit(sh_out),
        .rx_data(sh_rx)
    );

    // Fault never drops the drivers; only clearing serial enable or the master mode bit does
    assign SCK_O = sck_reg;
    assign SCK_OE = enabled && master;
    assign MOSI_O = sh_out;
    assign MOSI_OE = enabled && master;
    assign MISO_O = sh_out;
    assign MISO_OE = enabled && !master && state_reg == ST_SLAVE;
    assign CS_O = cs_reg;
    assign CS_OE = {4{enabled && master}};
    assign QUEUE_DONE = done_reg;
    assign MODE_FAULT = fault_reg;

    a_lead_gap_len: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && state_reg == ST_LOAD && enabled && cmd_next.lead_gap_on &&
        ctrl1_reg.lead_gap_len != 7'h00) |=> gap_reg == GAP_W'($past(ctrl1_reg.lead_gap_len)))
        else $error("lead gap count wrong");
    a_post_gap_len: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && xfer_end && enabled && cmd_reg.post_gap_on && ctrl1_reg.post_gap_len != 8'h00)
        |=> gap_reg == GAP_W'({$past(ctrl1_reg.post_gap_len), 5'h00}))
        else $error("post gap count wrong");
    a_post_gap_std: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && xfer_end && enabled && !cmd_reg.post_gap_on) |=> state_reg == ST_POST &&
        gap_reg == 14'h0011)
        else $error("standard post gap not seventeen");
    a_done_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && enabled && state_reg == ST_POST && gap_reg == GAP_W'(1) &&
        ptr_reg == ctrl2_reg.queue_last_ptr) |=> done_reg && state_reg == ST_IDLE)
        else $error("done flag missed at last command");
    a_fault_on_select: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && fault_set) |=> fault_reg)
        else $error("mode fault not flagged");
    a_fault_keeps_drive: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (fault_reg && master && enabled) |-> SCK_OE && MOSI_OE && CS_OE == 4'hf)
        else $error("mode fault dropped drivers");
    a_release_selects: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && xfer_end && enabled && master) |=> CS_O == ($past(cmd_reg.keep_selects) ?
        $past(cs_reg) : $past(ctrl2_reg.port_pin_control)))
        else $error("select release wrong");
    a_width_select: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && enabled && state_reg == ST_LOAD && !cmd_next.width_select) |=>
        nbits_reg == 5'h08)
        else $error("byte width not chosen");
    a_slave_no_cs: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !master |-> CS_OE == 4'h0 && !SCK_OE)
        else $error("slave drives selects");
    a_queue_step: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (CE && enabled && state_reg == ST_POST && gap_reg == GAP_W'(1) &&
        ptr_reg != ctrl2_reg.queue_last_ptr) |=> ptr_reg == $past(ptr_reg) + 1'b1 &&
        state_reg == ST_LOAD)
        else $error("queue pointer did not step");
endmodule : qsq_queue
`default_nettype wire

// *** logic/qsq_shifter.sv ***
`default_nettype none
module qsq_shifter
    import qsq_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic clk, // Core clock
    input wire logic rstn, // Synchronous reset, low
    input wire logic ce, // Clock enable
    input wire logic load, // Load transmit word
    input wire logic [W-1:0] load_data, // Right-justified transmit word
    input wire logic [CNT_W-1:0] nbits, // Transfer length
    input wire logic sample, // Capture incoming bit
    input wire logic in_bit, // Incoming serial bit
    input wire logic shift, // Advance one bit
    output logic out_bit, // Outgoing serial bit
    output logic [W-1:0] rx_data // Received word, right-justified
);
    logic [W-1:0] sr_reg;
    logic rx_bit_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sr_reg <= '0;
        end else if (ce) begin
            if (load) begin
                sr_reg <= W'(load_data << (CNT_W'(W) - nbits));
            end else if (shift) begin
                sr_reg <= {sr_reg[W-2:0], rx_bit_reg};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_bit_reg <= 1'b0;
        end else if (ce && sample) begin
            rx_bit_reg <= in_bit;
        end
    end

    assign out_bit = sr_reg[W-1];
    // Word as it stands after the closing shift; bits above the length read zero
    assign rx_data = {sr_reg[W-2:0], rx_bit_reg} & qsq_mask(nbits);
endmodule : qsq_shifter
`default_nettype wire

// *** tb/qsq_periph.sv ***
`default_nettype none
module qsq_periph #(
    parameter logic [15:0] REPLY = 16'hc3a5
) (
    input wire logic sck, // Serial clock
    input wire logic sel_n, // Own select, low
    input wire logic mosi, // Data from master
    output logic miso, // Data to master
    output logic [15:0] cap // Last frame seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sr;
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sr = REPLY;
        cap = '0;
        miso = sr[15];
    end
    always @(posedge sck) if (!sel_n) cap = {cap[14:0], mosi};
    always @(negedge sck) if (!sel_n) begin
        sr = {sr[14:0], 1'b0};
        miso = sr[15];
    end
    // Released line must not keep a stale level
    always @(posedge sel_n) miso = ~miso;
endmodule : qsq_periph
`default_nettype wire

// *** tb/qsq_queue_tb_top.sv ***
`default_nettype none
module qsq_queue_tb_top
    import qsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, sck_i = 0, mosi_i = 0, ss_n = 1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_i, done, fault;
    logic [3:0] cs_o, cs_oe;
    logic [15:0] cap;
    logic [7:0] so;
    int bad_count = 0, check_count = 0, cyc = 0;
    always #5 clk = ~clk;
    qsq_queue #(.POST_GAP_ZERO(14'h0040)) dut (.CORE_CLK(clk), .RSTN(rstn),
        .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SCK_O(sck_o), .SCK_OE(sck_oe), .SCK_I(sck_i), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MOSI_I(mosi_i), .MISO_O(miso_o), .MISO_OE(miso_oe),
        .MISO_I(miso_i), .CS_O(cs_o), .CS_OE(cs_oe), .SS_N_I(ss_n),
        .QUEUE_DONE(done), .MODE_FAULT(fault));
    qsq_periph peer (.sck(sck_o), .sel_n(cs_o[2]), .mosi(mosi_o), .miso(miso_i),
        .cap(cap));
    task automatic report_and_stop;
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(rdata, e);
    endtask : chk_reg
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        cmp({15'h0, done}, 16'h0001);
    endtask : wait_done
    // Link clock runs only inside the frame, 125 ns period
    task automatic slave_xfer(input logic [7:0] d);
        ss_n <= 1'b0;
        #200;
        for (int i = 0; i < 8; i++) begin
            mosi_i <= d[7-i];
            #62.5 so[7-i] = miso_o;
            sck_i <= 1'b1;
            if (i == 4) cmp({14'h0, miso_oe, |cs_oe}, 16'h0002);
            #62.5 sck_i <= 1'b0;
        end
        #200 ss_n <= 1'b1;
    endtask : slave_xfer
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        chk_reg(ADDR_CTRL0, CTRL0_RST);
        chk_reg(ADDR_CTRL2, CTRL2_RST);
        chk_reg(6'h34, 16'h0000);
        wr_reg(6'h0f, 16'h008b);
        wr_reg(6'h00, 16'h007b);
        chk_reg(6'h00, 16'h007b);
        wr_reg(6'h1f, 16'h003c);
        wr_reg(6'h10, 16'h0a5c);
        wr_reg(ADDR_CTRL0, 16'h808c);
        wr_reg(ADDR_CTRL2, 16'hf00f);
        wr_reg(ADDR_CTRL1, 16'h8502);
        repeat (4) @(posedge clk);
        #1 cmp({12'h0, cs_o}, 16'h000b);
        wait_done();
        chk_reg(6'h2f, 16'h00c3);
        chk_reg(6'h20, 16'h0a50);
        cmp(cap, 16'hca5c);
        cmp({12'h0, cs_o}, 16'h000f);
        chk_reg(ADDR_STAT, 16'h0080);
        chk_reg(6'h0f, 16'h008b);
        @(posedge clk);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 cmp({14'h0, fault, cs_o[0]}, 16'h0003);
        cmp({14'h0, sck_oe, mosi_oe}, 16'h0003);
        chk_reg(ADDR_CTRL0, 16'h808c);
        @(posedge clk);
        ss_n <= 1'b1;
        repeat (3) @(posedge clk);
        wr_reg(ADDR_STAT, 16'h00c0);
        wr_reg(ADDR_CTRL1, 16'h0502);
        @(posedge clk);
        #1 cmp({10'h0, sck_oe, mosi_oe, cs_oe}, 16'h0000);
        chk_reg(ADDR_STAT, 16'h0000);
        wr_reg(ADDR_CTRL2, 16'hf303);
        wr_reg(6'h13, 16'h0069);
        wr_reg(ADDR_CTRL0, 16'h0088);
        wr_reg(ADDR_CTRL1, 16'h8502);
        slave_xfer(8'h96);
        cmp({8'h0, so}, 16'h0069);
        wait_done();
        chk_reg(6'h23, 16'h0096);
        report_and_stop();
    end
endmodule : qsq_queue_tb_top
`default_nettype wire
